// ===== hw/fss_mono.sv
// retriggerable monostable: each trigger reloads the full period
// assumes trig is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module fss_mono #(
	parameter int unsigned PERIOD = 1
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	fss_mono_if.mono mono_if
);
	typedef struct packed {
		fss_pkg::fss_mono_state_type st;
		logic [fss_pkg::CNT_W-1:0] cnt;
	} fss_mono_reg_type;

	fss_mono_reg_type s_r;
	fss_mono_reg_type s_nxt;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			fss_pkg::FSS_IDLE: begin
				if (mono_if.trig) begin
					s_nxt.st = fss_pkg::FSS_ACTIVE;
					s_nxt.cnt = fss_pkg::CNT_W'(PERIOD - 1);
				end
			end
			fss_pkg::FSS_ACTIVE: begin
				// a retrigger wins over expiry in the same cycle
				if (mono_if.trig) begin
					s_nxt.cnt = fss_pkg::CNT_W'(PERIOD - 1);
				end else if (s_r.cnt == fss_pkg::CNT_RESET) begin
					s_nxt.st = fss_pkg::FSS_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			default: begin
				s_nxt.st = fss_pkg::FSS_IDLE;
				s_nxt.cnt = fss_pkg::CNT_RESET;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_r.st <= fss_pkg::FSS_IDLE;
			s_r.cnt <= fss_pkg::CNT_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mono_if.active = (s_r.st == fss_pkg::FSS_ACTIVE);
	assign mono_if.expired = (s_r.st == fss_pkg::FSS_IDLE);
endmodule

// ===== hw/fss_mono_if.sv
// carrier between the supervisor top and its monostable instances
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface fss_mono_if;
	logic trig;
	logic active;
	logic expired;
	modport ctl (output trig, input active, input expired);
	modport mono (input trig, output active, output expired);
endinterface

// ===== hw/fss_pkg.sv
// fail-safe supervisor constants: times, derived cycle counts, state codes
// assumes a 100 MHz board clock
package fss_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 100;
	localparam int FAST_TIME_US = 12;
	localparam int SW_TIME_MS = 13;
	localparam int HW_TIME_MS = 36;
	// a longest time rounds down; exact at 100 MHz anyway
	localparam int FAST_CYCLES = FAST_TIME_US * CLK_MHZ;
	localparam int SW_CYCLES = SW_TIME_MS * 1000 * CLK_MHZ;
	localparam int HW_CYCLES = HW_TIME_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;
	localparam logic [CNT_W-1:0] CNT_RESET = 32'h0;
	localparam logic [2:0] SYNC_RESET = 3'h0;

	// ****************************************
	// states of each monostable
	// ****************************************
	typedef enum logic [1:0] {
		FSS_IDLE = 2'b01,
		FSS_ACTIVE = 2'b10
	} fss_mono_state_type;
endpackage

// ===== hw/fss_top.sv
// fail-safe supervisor top: three monostables gating drives, nmi and resets
// assumes address latch, kicks, init and option straps arrive asynchronously
`timescale 1ns/1ps
module fss_top #(
	parameter int unsigned SW_CYCLES = fss_pkg::SW_CYCLES,
	parameter int unsigned HW_CYCLES = fss_pkg::HW_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic addr_latch_in,
	input wire logic sw_kick_in,
	input wire logic hw_kick_in,
	input wire logic bus_init_in,
	input wire logic opt_nmi_in,
	input wire logic opt_wd_reset_in,
	input wire logic opt_bus_reset_in,
	output logic drive_en_out,
	output logic run_green_out,
	output logic run_red_out,
	output logic nmi_out,
	output logic board_reset_out,
	output logic cpu_reset_out
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0] ale_s;
		logic [2:0] swk_s;
		logic [2:0] hwk_s;
		logic [2:0] init_s;
		logic [2:0] onmi_s;
		logic [2:0] owd_s;
		logic [2:0] obus_s;
		logic ale_q;
		logic swk_q;
		logic hwk_q;
		logic init_q;
		logic onmi_q;
		logic owd_q;
		logic obus_q;
		logic [fss_pkg::CNT_W-1:0] quiet;
		logic drive_en;
		logic run_green;
		logic run_red;
		logic nmi;
		logic board_reset;
		logic cpu_reset;
	} fss_top_reg_type;

	fss_top_reg_type s_r;
	fss_top_reg_type s_nxt;

	fss_mono_if fast_if ();
	fss_mono_if sw_if ();
	fss_mono_if hw_if ();

	// a change counts once the second and third stages agree
	function automatic logic fss_agree(input logic [2:0] sy, input logic prev);
		fss_agree = (sy[1] == sy[2]) ? sy[2] : prev;
	endfunction

	logic ale_v;
	logic swk_v;
	logic hwk_v;
	logic init_v;
	logic onmi_v;
	logic owd_v;
	logic obus_v;
	always_comb begin
		ale_v = fss_agree(s_r.ale_s, s_r.ale_q);
		swk_v = fss_agree(s_r.swk_s, s_r.swk_q);
		hwk_v = fss_agree(s_r.hwk_s, s_r.hwk_q);
		init_v = fss_agree(s_r.init_s, s_r.init_q);
		onmi_v = fss_agree(s_r.onmi_s, s_r.onmi_q);
		owd_v = fss_agree(s_r.owd_s, s_r.owd_q);
		obus_v = fss_agree(s_r.obus_s, s_r.obus_q);
	end

	// ****************************************
	// retrigger pulses
	// ****************************************
	assign fast_if.trig = ale_v & ~s_r.ale_q;
	// firmware kicks on either edge so a toggling port bit works
	assign sw_if.trig = swk_v ^ s_r.swk_q;
	assign hw_if.trig = hwk_v ^ s_r.hwk_q;

	fss_mono #(.PERIOD(fss_pkg::FAST_CYCLES)) u_fast (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.mono_if(fast_if)
	);
	fss_mono #(.PERIOD(SW_CYCLES)) u_sw (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.mono_if(sw_if)
	);
	fss_mono #(.PERIOD(HW_CYCLES)) u_hw (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.mono_if(hw_if)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.ale_s = {s_r.ale_s[1:0], addr_latch_in};
		s_nxt.swk_s = {s_r.swk_s[1:0], sw_kick_in};
		s_nxt.hwk_s = {s_r.hwk_s[1:0], hw_kick_in};
		s_nxt.init_s = {s_r.init_s[1:0], bus_init_in};
		s_nxt.onmi_s = {s_r.onmi_s[1:0], opt_nmi_in};
		s_nxt.owd_s = {s_r.owd_s[1:0], opt_wd_reset_in};
		s_nxt.obus_s = {s_r.obus_s[1:0], opt_bus_reset_in};
		s_nxt.ale_q = ale_v;
		s_nxt.swk_q = swk_v;
		s_nxt.hwk_q = hwk_v;
		s_nxt.init_q = init_v;
		s_nxt.onmi_q = onmi_v;
		s_nxt.owd_q = owd_v;
		s_nxt.obus_q = obus_v;
		// cycles since the last accepted latch edge, saturating; only the expiry check reads it
		if (fast_if.trig) begin
			s_nxt.quiet = fss_pkg::CNT_RESET;
		end else if (!(&s_r.quiet)) begin
			s_nxt.quiet = s_r.quiet + 1'b1;
		end
		// no firmware path here: the drives follow the monostable alone
		s_nxt.drive_en = fast_if.active;
		s_nxt.run_green = fast_if.active;
		s_nxt.run_red = fast_if.expired;
		// options are only honoured, never forced on
		s_nxt.nmi = onmi_v & sw_if.expired;
		s_nxt.board_reset = owd_v & hw_if.expired;
		// held cpu stops the latch, so the fast timer lapses by itself
		s_nxt.cpu_reset = (obus_v & init_v) | (owd_v & hw_if.expired);
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_r <= '0;
			s_r.run_red <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign drive_en_out = s_r.drive_en;
	assign run_green_out = s_r.run_green;
	assign run_red_out = s_r.run_red;
	assign nmi_out = s_r.nmi;
	assign board_reset_out = s_r.board_reset;
	assign cpu_reset_out = s_r.cpu_reset;

	// ****************************************
	// checks
	// ****************************************
	property p_fast_trig;
		@(posedge clock_in) disable iff (!rst_b_in)
		fast_if.trig |=> ##1 drive_en_out;
	endproperty
	a_fast_trig: assert property (p_fast_trig) else $error("drive not enabled after latch edge");

	property p_green_drive;
		@(posedge clock_in) disable iff (!rst_b_in)
		run_green_out == drive_en_out && run_red_out == !drive_en_out;
	endproperty
	a_green_drive: assert property (p_green_drive) else $error("lamp and drive disagree");

	property p_fast_expire;
		@(posedge clock_in) disable iff (!rst_b_in)
		$fell(fast_if.active) |=> !drive_en_out && run_red_out;
	endproperty
	a_fast_expire: assert property (p_fast_expire) else $error("drive still on after expiry");

	property p_sw_hold;
		@(posedge clock_in) disable iff (!rst_b_in)
		sw_if.trig |=> sw_if.active [*8];
	endproperty
	a_sw_hold: assert property (p_sw_hold) else $error("software monostable dropped early");

	property p_nmi;
		@(posedge clock_in) disable iff (!rst_b_in)
		nmi_out |-> $past(onmi_v) && $past(sw_if.expired);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi without option or expiry");

	property p_board_reset;
		@(posedge clock_in) disable iff (!rst_b_in)
		(owd_v && hw_if.expired) |=> board_reset_out;
	endproperty
	a_board_reset: assert property (p_board_reset) else $error("board reset missing");

	property p_bus_reset;
		@(posedge clock_in) disable iff (!rst_b_in)
		(obus_v && init_v) |=> cpu_reset_out;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("cpu not held by bus init");

	property p_quiet_expire;
		@(posedge clock_in) disable iff (!rst_b_in)
		// a full fast period with no latch edge, as while the cpu is held, must leave the drives off
		(s_r.quiet > fss_pkg::FAST_CYCLES) |-> !drive_en_out && run_red_out;
	endproperty
	a_quiet_expire: assert property (p_quiet_expire) else $error("drive on with no latch activity");

	c_drive_on: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(drive_en_out));
	c_drive_off: cover property (@(posedge clock_in) disable iff (!rst_b_in) $fell(drive_en_out));
	c_nmi: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(nmi_out));
	c_board_reset: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(board_reset_out));
endmodule

// ===== tb/fss_cpu_model.sv
// processor and firmware stand-in for the fail-safe supervisor
// assumes one clock; outputs change 1 ns after the rising edge
`timescale 1ns/1ps
module fss_cpu_model (
	input wire logic clock_in,
	input wire logic cpu_reset_in,
	input wire logic nmi_in,
	input wire logic ale_en_in,
	input wire logic sw_en_in,
	input wire logic hw_en_in,
	output logic addr_latch_out,
	output logic sw_kick_out,
	output logic hw_kick_out
);
	// ****************************************
	// program loop
	// ****************************************
	logic [7:0] pc_r = 8'h00;
	logic ale_r = 1'b0;
	logic swk_r = 1'b0;
	logic hwk_r = 1'b0;
	assign addr_latch_out = ale_r;
	assign sw_kick_out = swk_r;
	assign hw_kick_out = hwk_r;
	always @(posedge clock_in) begin
		if (cpu_reset_in) begin
			pc_r <= 8'h00;
			ale_r <= #1 1'b0;
		end else if (nmi_in && pc_r > 8'h10) begin
			pc_r <= 8'h00;
		end else begin
			pc_r <= pc_r + 8'h01;
			ale_r <= #1 ale_en_in & pc_r[2];
			// kick period stands in for the millisecond loop, scaled with the timers
			if (pc_r[3:0] == 4'hf) begin
				swk_r <= #1 swk_r ^ sw_en_in;
				hwk_r <= #1 hwk_r ^ hw_en_in;
			end
		end
	end
endmodule

// ===== tb/fss_top_tb_top.sv
// self-checking bench for the fail-safe supervisor top
// assumes the processor stand-in drives the latch and kick pins
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch %0t %h %h", $time, a, b); end end
module fss_top_tb_top;
	// ****************************************
	// signals
	// ****************************************
	localparam int SW = 200;
	localparam int HW = 500;
	logic clock_in = 0, rst_b_in = 0, init = 0, o_nmi = 0, o_wd = 0, o_bus = 0;
	logic ale_en = 0, sw_en = 0, hw_en = 0;
	logic ale, swk, hwk, drv, grn, red, nmi, brd, cpr;
	logic [3:0] ex;
	logic [31:0] r;
	int n_mismatch = 0, n_tests = 0, cyc = 0, n;
	int seed = 32'h92cd8e5f;
	fss_top #(.SW_CYCLES(SW), .HW_CYCLES(HW)) u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.addr_latch_in(ale), .sw_kick_in(swk), .hw_kick_in(hwk), .bus_init_in(init), .opt_nmi_in(o_nmi),
		.opt_wd_reset_in(o_wd), .opt_bus_reset_in(o_bus), .drive_en_out(drv), .run_green_out(grn),
		.run_red_out(red), .nmi_out(nmi), .board_reset_out(brd), .cpu_reset_out(cpr));
	fss_cpu_model u_cpu (.clock_in(clock_in), .cpu_reset_in(cpr), .nmi_in(nmi), .ale_en_in(ale_en),
		.sw_en_in(sw_en), .hw_en_in(hw_en), .addr_latch_out(ale), .sw_kick_out(swk), .hw_kick_out(hwk));
	// ****************************************
	// helpers
	// ****************************************
	// a board reset also silences the firmware, so it stays stuck while its option is fitted
	function automatic logic [3:0] expect_outs(input logic on, ow, ob, it, swe, hwe, ae);
		logic held, b;
		b = ow & (!hwe | (ob & it));
		held = (ob & it) | b;
		return {ae & !held, on & (!swe | held), b, held};
	endfunction
	task automatic step(input int k);
		repeat (k) @(posedge clock_in);
		#1;
	endtask
	task automatic time_to(input int sel, output int k);
		k = 0;
		while (k < 2000 && !(sel == 0 ? drv === 1'b0 : sel == 1 ? nmi === 1'b1 : brd === 1'b1)) begin
			step(1);
			k++;
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ****************************************
	// clock, timeout, sequence
	// ****************************************
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		step(2);
		rst_b_in = 1;
		step(40);
		`CHK({drv, red}, 2'b01)
		ale_en = 1;
		sw_en = 1;
		hw_en = 1;
		step(40);
		`CHK({drv, grn, red}, 3'b110)
		ale_en = 0;
		time_to(0, n);
		`CHK(n >= 1190 && n <= 1206, 1'b1)
		ale_en = 1;
		o_nmi = 1;
		sw_en = 0;
		time_to(1, n);
		`CHK(n >= SW - 20 && n <= SW + 10, 1'b1)
		sw_en = 1;
		o_wd = 1;
		hw_en = 0;
		time_to(2, n);
		`CHK(n >= HW - 20 && n <= HW + 10, 1'b1)
		step(4);
		`CHK(cpr, 1'b1)
		o_wd = 0;
		hw_en = 1;
		step(50);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			{o_nmi, o_wd, o_bus, init, sw_en, hw_en, ale_en} = r[6:0];
			// first pass forces the bus init hold
			if (i == 0) begin
				{o_bus, init} = 2'b11;
			end
			// reset option strapped late: a stale hardware expiry would otherwise race the first kick
			o_wd = 1'b0;
			step(100);
			o_wd = r[5];
			step(1900);
			ex = expect_outs(o_nmi, o_wd, o_bus, init, sw_en, hw_en, ale_en);
			`CHK({drv, grn, red}, {ex[3], ex[3], !ex[3]})
			`CHK(nmi, ex[2])
			`CHK(brd, ex[1])
			`CHK(cpr, ex[0])
		end
		close_out();
	end
endmodule
